// [rtl/pmisr_consts.vh]
// Constants for the interrupt and status register group
// Assumes an 8-bit register port with 8-bit addresses
`ifndef PMISR_CONSTS_VH
`define PMISR_CONSTS_VH
`define PMISR_ADDR_RESET     8'h1F
`define PMISR_ADDR_TOP1      8'h20
`define PMISR_ADDR_TOP2      8'h21
`define PMISR_ADDR_BUCK      8'h22
`define PMISR_ADDR_BOOST     8'h23
`define PMISR_ADDR_DIAG      8'h24
`define PMISR_ADDR_TOPST     8'h25
`define PMISR_ADDR_BUCKST    8'h26
`define PMISR_ADDR_BOOSTST   8'h27
`define PMISR_ADDR_TOPMASK   8'h29
`define PMISR_ADDR_TOP2MASK  8'h2A
`define PMISR_ADDR_BUCKMASK  8'h2B
`define PMISR_ADDR_BOOSTMASK 8'h2C
`define PMISR_ADDR_DIAGMASK  8'h2D
`define PMISR_ZERO8          8'h00
`define PMISR_TOP2MASK_RST   8'h01
`define PMISR_TOP1_LATCH     8'h8F
`define PMISR_BUCK_USED      8'h77
`define PMISR_BOOST_USED     8'h07
`define PMISR_DIAG_USED      8'h15
`define PMISR_TWARN_MASK     8'h02
`define PMISR_BIT_SWRST      0
`define PMISR_BIT_MEAS       7
`define PMISR_BIT_DIAGSUM    6
`define PMISR_BIT_BOOSTSUM   5
`define PMISR_BIT_BUCKSUM    4
`define PMISR_BIT_CLK        3
`define PMISR_BIT_TSD        2
`define PMISR_BIT_TWARN      1
`define PMISR_BIT_OVP        0
`define PMISR_BIT_REGRST     0
`endif

// [rtl/pmisr_regs.v]
// Interrupt flag, status and software reset registers of the power manager
// Assumes an 8-bit register port already decoded from the serial interface, events
// as one-cycle pulses from the analog side, live conditions as synchronous levels
// Functional notes
// - Soft reset write restores defaults, requests settings reload, bit self-clears.
// - Current measurement ready latches bit 7 of top flags, write 1 clears.
// - Monitor summary reads 1 while monitor flags are nonzero.
// - Booster summary bit 5 reflects any pending booster flag.
// - Step-down summary reflects any pending step-down flag.
// - External clock validity change either way latches bit 3.
// - Thermal shutdown latches bit 2, disables converters, blocks enabling while set.
// - Clearing thermal shutdown re-enables converters and clears thermal warning.
// - Thermal warning latches bit 1 until write 1 or a thermal shutdown clear; live state separate.
// - Input overvoltage latches bit 0; only write 1 clears.
// - Register-reset flag latches on supply undervoltage or soft reset.
// - Step-down power-good event flags at bits 6 and 2.
// - Step-down short flags latch on short events, write 1 clears.
// - Step-down current limit flags at bits 4 and 0.
// - Booster power-good at bit 2 and current limit at bit 0.
// - Booster short flag latches on short event.
// - Monitor power-good flags at bits 4, 2 and 0.
// - Top status bit 3 reads 1 when external clock is invalid.
// - Top status bits 2..0 show live shutdown, warning, overvoltage.
// - Step-down status bits 7 and 3 show converter enable.
// - Step-down status bits 6, 2 valid and 4, 0 current limit live.
// - Booster status bit 3 enable, bit 2 output valid.
// - Mask bits gate flags from interrupt only, not status.
`timescale 1ns/1ps
`include "pmisr_consts.vh"

module pmisr_regs (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       uvlo_in,
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    output reg  [7:0] reg_rdata_out,
    input  wire       meas_done_in,
    input  wire       clk_valid_in,
    input  wire       tsd_live_in,
    input  wire       twarn_live_in,
    input  wire       ovp_live_in,
    input  wire [2:0] stepdown_a_ev_in,
    input  wire [2:0] stepdown_b_ev_in,
    input  wire [2:0] booster_ev_in,
    input  wire [2:0] monitor_ev_in,
    input  wire       stepdown_a_en_req_in,
    input  wire       stepdown_b_en_req_in,
    input  wire       booster_en_req_in,
    input  wire       stepdown_a_valid_live_in,
    input  wire       stepdown_b_valid_live_in,
    input  wire       stepdown_a_curlim_live_in,
    input  wire       stepdown_b_curlim_live_in,
    input  wire       booster_valid_live_in,
    output reg        stepdown_a_en_out,
    output reg        stepdown_b_en_out,
    output reg        booster_en_out,
    output reg        settings_reload_out,
    output wire       irq_out
);

    reg  [7:0] top_interrupt_flags;
    reg        register_reset_interrupt;
    reg  [7:0] stepdown_interrupt_flags;
    reg  [7:0] booster_interrupt_flags;
    reg  [7:0] monitor_interrupt_flags;
    reg  [7:0] top_mask;
    reg        top2_mask;
    reg  [7:0] stepdown_mask;
    reg  [7:0] booster_mask;
    reg  [7:0] monitor_mask;
    reg        clk_valid_q;
    reg        soft_reset_cmd;
    reg        uvlo_q;

    wire       soft_rst;
    wire       regs_rst;
    wire [7:0] top_live_status;
    wire [7:0] stepdown_live_status;
    wire [7:0] booster_live_status;
    wire [7:0] top_view;
    wire [7:0] top_set;
    wire [7:0] sd_set;
    wire [7:0] bo_set;
    wire [7:0] mon_set;
    wire       tsd_clear;
    wire [7:0] top_clr;
    wire       conv_block;

    // Register write strobe for one address
    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input       wr;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    // Write-one-to-clear with set winning over clear
    function [7:0] w1c;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        input [7:0] used;
        begin
            w1c = ((cur & ~clr) | set) & used;
        end
    endfunction

    assign soft_rst = wr_hit(reg_addr_in, `PMISR_ADDR_RESET, reg_wr_in)
                      && reg_wdata_in[`PMISR_BIT_SWRST];
    assign regs_rst = rst_in || soft_rst || uvlo_in;

    assign tsd_clear = wr_hit(reg_addr_in, `PMISR_ADDR_TOP1, reg_wr_in)
                       && reg_wdata_in[`PMISR_BIT_TSD]
                       && !tsd_live_in;
    assign conv_block = top_interrupt_flags[`PMISR_BIT_TSD] || tsd_live_in;

    // Host clears plus the warning flag dropped by a shutdown clear
    assign top_clr = ({8{wr_hit(reg_addr_in, `PMISR_ADDR_TOP1, reg_wr_in)}} & reg_wdata_in)
                     | ({8{tsd_clear}} & `PMISR_TWARN_MASK);

    assign top_set = {meas_done_in, 3'b000,
                      clk_valid_in ^ clk_valid_q,
                      tsd_live_in, twarn_live_in && !tsd_clear, ovp_live_in};
    assign sd_set  = {1'b0, stepdown_b_ev_in, 1'b0, stepdown_a_ev_in};
    assign bo_set  = {5'b00000, booster_ev_in};
    assign mon_set = {3'b000, monitor_ev_in[2], 1'b0, monitor_ev_in[1],
                      1'b0, monitor_ev_in[0]};

    assign top_view = {top_interrupt_flags[`PMISR_BIT_MEAS],
                       monitor_interrupt_flags != `PMISR_ZERO8,
                       booster_interrupt_flags != `PMISR_ZERO8,
                       stepdown_interrupt_flags != `PMISR_ZERO8,
                       top_interrupt_flags[3:0]};

    assign top_live_status = {4'b0000, !clk_valid_in,
                              tsd_live_in, twarn_live_in, ovp_live_in};
    assign stepdown_live_status = {stepdown_b_en_out, stepdown_b_valid_live_in, 1'b0,
                                   stepdown_b_curlim_live_in, stepdown_a_en_out,
                                   stepdown_a_valid_live_in, 1'b0,
                                   stepdown_a_curlim_live_in};
    assign booster_live_status = {4'b0000, booster_en_out, booster_valid_live_in,
                                  2'b00};

    assign irq_out = |(top_interrupt_flags & `PMISR_TOP1_LATCH & ~top_mask)
                     || (register_reset_interrupt && !top2_mask)
                     || |(stepdown_interrupt_flags & ~stepdown_mask)
                     || |(booster_interrupt_flags & ~booster_mask)
                     || |(monitor_interrupt_flags & ~monitor_mask);

    // Flag and mask registers
    always @(posedge clk_in) begin
        if (regs_rst) begin
            top_interrupt_flags      <= `PMISR_ZERO8;
            stepdown_interrupt_flags <= `PMISR_ZERO8;
            booster_interrupt_flags  <= `PMISR_ZERO8;
            monitor_interrupt_flags  <= `PMISR_ZERO8;
            top_mask                 <= `PMISR_ZERO8;
            top2_mask                <= 1'b1;
            stepdown_mask            <= `PMISR_ZERO8;
            booster_mask             <= `PMISR_ZERO8;
            monitor_mask             <= `PMISR_ZERO8;
        end else begin
            top_interrupt_flags <= w1c(top_interrupt_flags, top_set, top_clr,
                `PMISR_TOP1_LATCH);
            stepdown_interrupt_flags <= w1c(stepdown_interrupt_flags, sd_set,
                {8{wr_hit(reg_addr_in, `PMISR_ADDR_BUCK, reg_wr_in)}} & reg_wdata_in,
                `PMISR_BUCK_USED);
            booster_interrupt_flags <= w1c(booster_interrupt_flags, bo_set,
                {8{wr_hit(reg_addr_in, `PMISR_ADDR_BOOST, reg_wr_in)}} & reg_wdata_in,
                `PMISR_BOOST_USED);
            monitor_interrupt_flags <= w1c(monitor_interrupt_flags, mon_set,
                {8{wr_hit(reg_addr_in, `PMISR_ADDR_DIAG, reg_wr_in)}} & reg_wdata_in,
                `PMISR_DIAG_USED);
            if (wr_hit(reg_addr_in, `PMISR_ADDR_TOPMASK, reg_wr_in))
                top_mask <= reg_wdata_in;
            if (wr_hit(reg_addr_in, `PMISR_ADDR_TOP2MASK, reg_wr_in))
                top2_mask <= reg_wdata_in[0];
            if (wr_hit(reg_addr_in, `PMISR_ADDR_BUCKMASK, reg_wr_in))
                stepdown_mask <= reg_wdata_in;
            if (wr_hit(reg_addr_in, `PMISR_ADDR_BOOSTMASK, reg_wr_in))
                booster_mask <= reg_wdata_in;
            if (wr_hit(reg_addr_in, `PMISR_ADDR_DIAGMASK, reg_wr_in))
                monitor_mask <= reg_wdata_in;
        end
    end

    // Register-reset flag survives the reset it reports
    always @(posedge clk_in) begin
        uvlo_q <= uvlo_in;
        if (rst_in) begin
            register_reset_interrupt <= 1'b0;
            uvlo_q                   <= 1'b0;
        end else if (soft_rst || (uvlo_q && !uvlo_in)) begin
            register_reset_interrupt <= 1'b1;
        end else if (wr_hit(reg_addr_in, `PMISR_ADDR_TOP2, reg_wr_in)
                     && reg_wdata_in[`PMISR_BIT_REGRST]) begin
            register_reset_interrupt <= 1'b0;
        end
    end

    // Soft reset command, reload request and converter enables
    always @(posedge clk_in) begin
        if (rst_in) begin
            soft_reset_cmd      <= 1'b0;
            settings_reload_out <= 1'b0;
            clk_valid_q         <= 1'b1;
            stepdown_a_en_out   <= 1'b0;
            stepdown_b_en_out   <= 1'b0;
            booster_en_out      <= 1'b0;
        end else begin
            soft_reset_cmd      <= soft_rst;
            settings_reload_out <= soft_rst;
            clk_valid_q         <= clk_valid_in;
            if (regs_rst || conv_block) begin
                stepdown_a_en_out <= 1'b0;
                stepdown_b_en_out <= 1'b0;
                booster_en_out    <= 1'b0;
            end else begin
                stepdown_a_en_out <= stepdown_a_en_req_in;
                stepdown_b_en_out <= stepdown_b_en_req_in;
                booster_en_out    <= booster_en_req_in;
            end
        end
    end

    // Read data, registered; unmapped reads zero
    always @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= `PMISR_ZERO8;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `PMISR_ADDR_RESET)
                reg_rdata_out <= `PMISR_ZERO8;
            else if (reg_addr_in == `PMISR_ADDR_TOP1)
                reg_rdata_out <= top_view;
            else if (reg_addr_in == `PMISR_ADDR_TOP2)
                reg_rdata_out <= {7'b0000000, register_reset_interrupt};
            else if (reg_addr_in == `PMISR_ADDR_BUCK)
                reg_rdata_out <= stepdown_interrupt_flags;
            else if (reg_addr_in == `PMISR_ADDR_BOOST)
                reg_rdata_out <= booster_interrupt_flags;
            else if (reg_addr_in == `PMISR_ADDR_DIAG)
                reg_rdata_out <= monitor_interrupt_flags;
            else if (reg_addr_in == `PMISR_ADDR_TOPST)
                reg_rdata_out <= top_live_status;
            else if (reg_addr_in == `PMISR_ADDR_BUCKST)
                reg_rdata_out <= stepdown_live_status;
            else if (reg_addr_in == `PMISR_ADDR_BOOSTST)
                reg_rdata_out <= booster_live_status;
            else if (reg_addr_in == `PMISR_ADDR_TOPMASK)
                reg_rdata_out <= top_mask;
            else if (reg_addr_in == `PMISR_ADDR_TOP2MASK)
                reg_rdata_out <= {7'b0000000, top2_mask};
            else if (reg_addr_in == `PMISR_ADDR_BUCKMASK)
                reg_rdata_out <= stepdown_mask;
            else if (reg_addr_in == `PMISR_ADDR_BOOSTMASK)
                reg_rdata_out <= booster_mask;
            else if (reg_addr_in == `PMISR_ADDR_DIAGMASK)
                reg_rdata_out <= monitor_mask;
            else
                reg_rdata_out <= `PMISR_ZERO8;
        end
    end

endmodule // pmisr_regs

// [verif/pmisr_props.sv]
// Checker for the interrupt and status register group
// Sees only the top module ports; bound from the bench top
`timescale 1ns/1ps
module pmisr_props (
    input wire       clk_in,
    input wire       rst_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       clk_valid_in,
    input wire       tsd_live_in,
    input wire       twarn_live_in,
    input wire       ovp_live_in,
    input wire       stepdown_a_en_req_in,
    input wire       stepdown_a_valid_live_in,
    input wire       stepdown_b_valid_live_in,
    input wire       stepdown_a_curlim_live_in,
    input wire       stepdown_b_curlim_live_in,
    input wire       booster_valid_live_in,
    input wire       stepdown_a_en_out,
    input wire       stepdown_b_en_out,
    input wire       booster_en_out,
    input wire       settings_reload_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire       wr_cmd = reg_wr_in && reg_addr_in == 8'h1F && reg_wdata_in[0];
    wire       rd_cmd = reg_rd_in && reg_addr_in == 8'h1F;
    wire       rd_top = reg_rd_in && reg_addr_in == 8'h25;
    wire       rd_bk  = reg_rd_in && reg_addr_in == 8'h26;
    wire       rd_bo  = reg_rd_in && reg_addr_in == 8'h27;
    wire       any_en = stepdown_a_en_out | stepdown_b_en_out | booster_en_out;
    wire [7:0] top_x  = {4'h0, !clk_valid_in, tsd_live_in, twarn_live_in, ovp_live_in};
    wire [7:0] bk_x   = {stepdown_b_en_out, stepdown_b_valid_live_in, 1'b0,
                         stepdown_b_curlim_live_in, stepdown_a_en_out,
                         stepdown_a_valid_live_in, 1'b0, stepdown_a_curlim_live_in};
    wire [5:0] bo_x   = {4'h0, booster_en_out, booster_valid_live_in};
    reload_cmd_a: assert property (wr_cmd |=> settings_reload_out)
        else $error("reload pulse missing");
    reload_pulse_a: assert property (settings_reload_out |=> !settings_reload_out)
        else $error("reload pulse too long");
    cmd_zero_a: assert property (rd_cmd |=> reg_rdata_out == 8'h00)
        else $error("reset command reads nonzero");
    tsd_block_a: assert property (tsd_live_in |=> !any_en)
        else $error("converter enabled in shutdown");
    en_cause_a: assert property ($rose(stepdown_a_en_out) |->
        $past(stepdown_a_en_req_in) && !$past(tsd_live_in)) else $error("enable without cause");
    top_live_a: assert property (rd_top |=> reg_rdata_out == $past(top_x))
        else $error("top status wrong");
    buck_live_a: assert property (rd_bk |=> reg_rdata_out == $past(bk_x))
        else $error("step-down status wrong");
    boost_live_a: assert property (rd_bo |=> reg_rdata_out[7:2] == $past(bo_x))
        else $error("booster status wrong");
    cover property (wr_cmd);
    cover property (tsd_live_in && any_en);
    cover property (rd_bk && stepdown_b_en_out);
endmodule // pmisr_props

// [verif/pmisr_host.sv]
// Host model driving the register port of the interrupt and status group
// Assumes one-cycle strobes taken on a rising edge, read data one cycle later
`timescale 1ns/1ps
module pmisr_host (
    input  wire       clk_in,
    input  wire [7:0] rdata_in,
    output reg  [7:0] addr_out,
    output reg  [7:0] wdata_out,
    output reg        wr_out,
    output reg        rd_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Idle bus shows inverted address and write data after a write; a read inverts only the address
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
endmodule // pmisr_host

// [verif/pmisr_regs_tb_top.sv]
// Self-checking bench for the interrupt and status register group
// Assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module pmisr_regs_tb_top;
    logic       clk_in, rst_in, uvlo_in, meas_done_in, clk_valid_in;
    logic       tsd_live_in, twarn_live_in, ovp_live_in;
    logic [2:0] stepdown_a_ev_in, stepdown_b_ev_in, booster_ev_in, monitor_ev_in;
    logic       stepdown_a_en_req_in, stepdown_b_en_req_in, booster_en_req_in;
    logic       stepdown_a_valid_live_in, stepdown_b_valid_live_in, booster_valid_live_in;
    logic       stepdown_a_curlim_live_in, stepdown_b_curlim_live_in;
    wire  [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    wire        reg_wr_in, reg_rd_in, irq_out, settings_reload_out;
    wire        stepdown_a_en_out, stepdown_b_en_out, booster_en_out;
    int         fail_count, checks;
    wire  [7:0] en_v = {5'h0, stepdown_b_en_out, stepdown_a_en_out, booster_en_out};
    pmisr_regs i_pmisr_regs (.*);
    pmisr_host i_pmisr_host (.clk_in(clk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
        .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_pmisr_host.rd(a, d);
        chk(d, e);
    endtask
    task test_done;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task t_defaults;
        for (int a = 8'h1F; a <= 8'h27; a++) rdc(a[7:0], 8'h00);
        rdc(8'h30, 8'h00);
    endtask
    task t_top;
        @(posedge clk_in);
        {meas_done_in, clk_valid_in, tsd_live_in, twarn_live_in, ovp_live_in} <= 5'b10111;
        @(posedge clk_in);
        {meas_done_in, tsd_live_in, twarn_live_in, ovp_live_in} <= 4'h0;
        rdc(8'h25, 8'h08);
        rdc(8'h20, 8'h8F);
        i_pmisr_host.wr(8'h20, 8'h00);
        rdc(8'h20, 8'h8F);
        i_pmisr_host.wr(8'h20, 8'h88);
        rdc(8'h20, 8'h07);
        @(posedge clk_in);
        clk_valid_in <= 1'b1;
        rdc(8'h20, 8'h0F);
        i_pmisr_host.wr(8'h20, 8'h04);
        rdc(8'h20, 8'h09);
        i_pmisr_host.wr(8'h20, 8'h09);
        rdc(8'h20, 8'h00);
    endtask
    task t_subs;
        @(posedge clk_in);
        {stepdown_a_ev_in, stepdown_b_ev_in, booster_ev_in, monitor_ev_in} <= 12'hFFF;
        @(posedge clk_in);
        {stepdown_a_ev_in, stepdown_b_ev_in, booster_ev_in, monitor_ev_in} <= 12'h000;
        rdc(8'h22, 8'h77);
        rdc(8'h23, 8'h07);
        rdc(8'h24, 8'h15);
        rdc(8'h20, 8'h70);
        i_pmisr_host.wr(8'h23, 8'h03);
        rdc(8'h20, 8'h70);
        i_pmisr_host.wr(8'h23, 8'h04);
        i_pmisr_host.wr(8'h22, 8'h77);
        rdc(8'h20, 8'h40);
        i_pmisr_host.wr(8'h24, 8'h15);
        rdc(8'h20, 8'h00);
    endtask
    task t_enable;
        @(posedge clk_in);
        {stepdown_a_en_req_in, stepdown_b_en_req_in, booster_en_req_in} <= 3'b111;
        {stepdown_a_valid_live_in, stepdown_b_curlim_live_in, booster_valid_live_in} <= 3'b111;
        repeat (3) @(posedge clk_in);
        #1 chk(en_v, 8'h07);
        rdc(8'h26, 8'h9C);
        rdc(8'h27, 8'h0C);
        @(posedge clk_in);
        tsd_live_in <= 1'b1;
        @(posedge clk_in);
        tsd_live_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 chk(en_v, 8'h00);
        i_pmisr_host.wr(8'h20, 8'h04);
        repeat (3) @(posedge clk_in);
        #1 chk(en_v, 8'h07);
    endtask
    task t_soft;
        chk({7'h0, irq_out}, 8'h00);
        @(posedge clk_in);
        meas_done_in <= 1'b1;
        @(posedge clk_in);
        meas_done_in <= 1'b0;
        #1 chk({7'h0, irq_out}, 8'h01);
        i_pmisr_host.wr(8'h29, 8'h80);
        #1 chk({7'h0, irq_out}, 8'h00);
        i_pmisr_host.wr(8'h1F, 8'h01);
        repeat (2) @(posedge clk_in);
        rdc(8'h21, 8'h01);
        rdc(8'h1F, 8'h00);
        rdc(8'h20, 8'h00);
        rdc(8'h29, 8'h00);
        #1 chk({7'h0, irq_out}, 8'h00);
        i_pmisr_host.wr(8'h21, 8'h01);
        rdc(8'h21, 8'h00);
        @(posedge clk_in);
        uvlo_in <= 1'b1;
        @(posedge clk_in);
        uvlo_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rdc(8'h21, 8'h01);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        {rst_in, clk_valid_in} = 2'b11;
        {uvlo_in, meas_done_in, tsd_live_in, twarn_live_in, ovp_live_in} = 5'h00;
        {stepdown_a_ev_in, stepdown_b_ev_in, booster_ev_in, monitor_ev_in} = 12'h000;
        {stepdown_a_en_req_in, stepdown_b_en_req_in, booster_en_req_in} = 3'b000;
        {stepdown_a_valid_live_in, stepdown_b_valid_live_in, booster_valid_live_in} = 3'b000;
        {stepdown_a_curlim_live_in, stepdown_b_curlim_live_in} = 2'b00;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        t_defaults;
        t_top;
        t_subs;
        t_enable;
        t_soft;
        test_done;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        test_done;
    end
endmodule // pmisr_regs_tb_top
bind pmisr_regs pmisr_props i_pmisr_props (.*);
